/* dma_status_pkg.sv */
package dma_status_pkg;
  localparam int DATA_W = 64;
  localparam int ADDR_W = 8;
  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] STATUS_OFF = 8'h00;
  localparam logic [7:0] CONFIG_OFF = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFF = 8'h10;
  localparam logic [7:0] EVENT_OFF = 8'h18;
  // status field positions
  localparam int BIT_PAYLOAD_ERR = 0;
  localparam int BIT_DESC_ERR = 1;
  localparam int BIT_PCI_ERR = 2;
  localparam int BIT_SETUP_ERR = 3;
  localparam int BIT_XFER_DONE = 5;
  localparam int BIT_CHAIN_DONE = 6;
  localparam int BIT_ABNORMAL = 7;
  localparam int BIT_ACTIVE = 8;
  localparam int BIT_CHAIN_EN = 9;
  localparam int BIT_DONE_IRQ = 10;
  localparam int BIT_ERR_IRQ = 11;
  // config field positions
  localparam int CFG_ACTIVE = 0;
  localparam int CFG_CHAIN_EN = 1;
  localparam int CFG_CHAIN_IE = 2;
  localparam int CFG_XFER_IE = 3;
  // event register holds the six sticky flags, bits 6,5 and 3..0 of status
  localparam int EV_W = 7;
  localparam logic [6:0] EV_W1C_MASK = 7'h6F;
  localparam logic [6:0] EV_RESET = 7'h00;
  localparam logic [3:0] CFG_RESET = 4'h0;
  localparam logic [6:0] MASK_RESET = 7'h00;

  typedef struct packed {
    logic chain_done;
    logic xfer_done;
    logic setup_mismatch;
    logic pci_fatal;
    logic desc_bus_err;
    logic payload_bus_err;
  } dma_events_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

/* event_flags.sv */
`timescale 1ns/1ps
module event_flags
  import dma_status_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [EV_W-1:0] set_i,
  input wire logic [EV_W-1:0] clear_i,
  output logic [EV_W-1:0] flags_o
);
  // set wins over a clear in the same cycle
  genvar g;
  generate
    for (g = 0; g < EV_W; g++)
    begin : g_flag
      always_ff @(posedge clk_sys_i or posedge rst_i)
      begin
        if (rst_i)
          flags_o[g] <= EV_RESET[g];
        else if (set_i[g])
          flags_o[g] <= 1'b1;
        else if (clear_i[g])
          flags_o[g] <= 1'b0;
      end
    end
  endgenerate
endmodule

/* event_mapper.sv */
`timescale 1ns/1ps
module event_mapper
  import dma_status_pkg::*;
(
  input wire dma_status_pkg::dma_events_t ev_i,
  input wire logic chain_active_i,
  output logic [EV_W-1:0] set_o,
  output logic halt_o
);
  always_comb
  begin
    set_o = '0;
    set_o[BIT_PAYLOAD_ERR] = ev_i.payload_bus_err;
    set_o[BIT_DESC_ERR] = ev_i.desc_bus_err & chain_active_i;
    set_o[BIT_PCI_ERR] = ev_i.pci_fatal & chain_active_i;
    set_o[BIT_SETUP_ERR] = ev_i.setup_mismatch;
    set_o[BIT_XFER_DONE] = ev_i.xfer_done;
    set_o[BIT_CHAIN_DONE] = ev_i.chain_done;
    // pci fatal error is recorded but does not halt
    halt_o = ev_i.payload_bus_err | set_o[BIT_DESC_ERR]
      | ev_i.setup_mismatch;
  end
endmodule

/* pci_dma_status_flags.sv */
// Operation
// - status bit 8 mirrors the transfer-active configuration bit always.
// - status bit 7 is read-only OR of error bits 3 to 0.
// - status bit 6 sets on clean chain end, write-one clears.
// - status bit 5 sets on clean data transfer end, write-one clears.
// - status bit 3 sets and halts on setting mismatch, write-one clears.
// - status bit 2 sets on PCI bus error during chaining.
// - status bit 1 sets and halts on internal bus chain error.
// - status bit 0 sets and halts on internal bus data error.
// - bit 10 high when chain-done and enable, or xfer-done and enable.
`timescale 1ns/1ps
module pci_dma_status_flags
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [dma_status_pkg::ADDR_W-1:0] addr_i,
  input wire logic [dma_status_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire dma_status_pkg::dma_events_t events_i,
  input wire logic xfer_finish_i,
  output logic [dma_status_pkg::DATA_W-1:0] rdata_o,
  output logic transfer_active_o,
  output logic chain_enable_o,
  output logic dma_halt_o,
  output logic irq_o
);
  import dma_status_pkg::*;

  reg_req_t req;
  logic [3:0] cfg_reg;
  logic [EV_W-1:0] mask_reg;
  logic [EV_W-1:0] flags;
  logic [EV_W-1:0] set_v;
  logic [EV_W-1:0] clr_v;
  logic halt_req;
  logic abnormal_chain_done;
  logic normal_done_irq_status;
  logic error_irq_status;
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] rdata_next;
  logic irq_next;

  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] off);
    hit = (a == off);
  endfunction

  event_mapper u_map (
    .ev_i(events_i),
    .chain_active_i(cfg_reg[CFG_CHAIN_EN]),
    .set_o(set_v),
    .halt_o(halt_req)
  );

  // only bits 6,5,3..0 are write-one-clear; bit 4 stays zero
  assign clr_v = (req.wr && hit(req.addr, STATUS_OFF))
    ? (req.wdata[EV_W-1:0] & EV_W1C_MASK) : '0;

  event_flags u_flags (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .set_i(set_v & EV_W1C_MASK),
    .clear_i(clr_v),
    .flags_o(flags)
  );

  assign abnormal_chain_done = |flags[BIT_SETUP_ERR:BIT_PAYLOAD_ERR];
  assign normal_done_irq_status =
    (flags[BIT_CHAIN_DONE] & cfg_reg[CFG_CHAIN_IE])
    | (flags[BIT_XFER_DONE] & cfg_reg[CFG_XFER_IE]);
  assign error_irq_status = abnormal_chain_done;

  always_comb
  begin
    status_word = '0;
    status_word[EV_W-1:0] = flags & EV_W1C_MASK;
    status_word[BIT_ABNORMAL] = abnormal_chain_done;
    status_word[BIT_ACTIVE] = cfg_reg[CFG_ACTIVE];
    status_word[BIT_CHAIN_EN] = cfg_reg[CFG_CHAIN_EN];
    status_word[BIT_DONE_IRQ] = normal_done_irq_status;
    status_word[BIT_ERR_IRQ] = error_irq_status;
  end

  // configuration: software sets, hardware halt or transfer finish drops transfer-active
  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      cfg_reg <= CFG_RESET;
    else
    begin
      if (req.wr && hit(req.addr, CONFIG_OFF))
        cfg_reg <= req.wdata[3:0];
      if (halt_req || xfer_finish_i)
        cfg_reg[CFG_ACTIVE] <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      mask_reg <= MASK_RESET;
    else if (req.wr && hit(req.addr, IRQ_MASK_OFF))
      mask_reg <= req.wdata[EV_W-1:0] & EV_W1C_MASK;
  end

  always_comb
  begin
    rdata_next = '0;
    if (req.rd)
    begin
      if (hit(req.addr, STATUS_OFF))
        rdata_next = status_word;
      else if (hit(req.addr, CONFIG_OFF))
        rdata_next[3:0] = cfg_reg;
      else if (hit(req.addr, IRQ_MASK_OFF))
        rdata_next[EV_W-1:0] = mask_reg;
      else if (hit(req.addr, EVENT_OFF))
        rdata_next[EV_W-1:0] = flags & EV_W1C_MASK;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= '0;
    else
      rdata_o <= rdata_next;
  end

  assign irq_next = |(flags & mask_reg & EV_W1C_MASK);

  always_ff @(posedge clk_sys_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      irq_o <= 1'b0;
      dma_halt_o <= 1'b0;
      transfer_active_o <= 1'b0;
      chain_enable_o <= 1'b0;
    end
    else
    begin
      irq_o <= irq_next;
      dma_halt_o <= halt_req;
      transfer_active_o <= cfg_reg[CFG_ACTIVE];
      chain_enable_o <= cfg_reg[CFG_CHAIN_EN];
    end
  end
endmodule

/* pci_dma_status_flags_asserts.sv */
`timescale 1ns/1ps
module pci_dma_status_flags_asserts
  import dma_status_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire dma_events_t events_i,
  input wire logic xfer_finish_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic transfer_active_o,
  input wire logic chain_enable_o,
  input wire logic dma_halt_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  wire sr = rd_i && addr_i == STATUS_OFF;
  active_mirror_a: assert property (
    sr |=> rdata_o[8] == transfer_active_o)
    else $error("active mirror wrong");
  abn_or_a: assert property (sr |=> rdata_o[7] == |rdata_o[3:0])
    else $error("abnormal flag wrong");
  rsv_zero_a: assert property (sr |=> !rdata_o[4])
    else $error("reserved bit set");
  setup_halt_a: assert property (
    events_i.setup_mismatch |=> dma_halt_o) else $error("no halt on setup");
  desc_halt_a: assert property (
    events_i.desc_bus_err ##1 chain_enable_o |-> dma_halt_o)
    else $error("no halt on chain error");
  pay_halt_a: assert property (
    events_i.payload_bus_err |=> dma_halt_o) else $error("no halt on data");
  halt_stop_a: assert property (dma_halt_o |=> !transfer_active_o)
    else $error("active after halt");
  fin_stop_a: assert property (xfer_finish_i |-> ##2 !transfer_active_o)
    else $error("active after finish");
  cover property (events_i.chain_done ##2 irq_o);
  cover property (sr ##1 rdata_o[7]);
  cover property (dma_halt_o);
endmodule
bind pci_dma_status_flags pci_dma_status_flags_asserts i_chk (.*);

/* dma_engine_model.sv */
`timescale 1ns/1ps
module dma_engine_model
  import dma_status_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [6:0] req_i,
  output dma_events_t events_o,
  output logic xfer_finish_o
);
  // one-cycle event and finish pulses, as the engine raises them
  always_ff @(posedge clk_sys_i or posedge rst_i)
    if (rst_i)
      {xfer_finish_o, events_o} <= 7'h00;
    else
      {xfer_finish_o, events_o} <= req_i;
endmodule

/* pci_dma_status_flags_tb_top.sv */
`timescale 1ns/1ps
module pci_dma_status_flags_tb_top;
  import dma_status_pkg::*;
  logic clk_sys_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
  logic [7:0] addr_i = 8'h00;
  logic [63:0] wdata_i = 64'h0, rdata_o;
  logic [6:0] req = 7'h00;
  dma_events_t events_i;
  logic xfer_finish_i, act_o, irq_o, ch_o, halt_o;
  int n_fail = 0, checks_done = 0, fl = 0, cfg = 0, k, i, m, d, h;
  always #2 clk_sys_i = ~clk_sys_i;
  pci_dma_status_flags i_pci_dma_status_flags (.clk_sys_i, .rst_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .events_i, .xfer_finish_i, .rdata_o,
    .transfer_active_o(act_o), .chain_enable_o(ch_o), .dma_halt_o(halt_o),
    .irq_o);
  dma_engine_model i_dma_engine_model (.clk_sys_i, .rst_i, .req_i(req),
    .events_o(events_i), .xfer_finish_o(xfer_finish_i));
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input int v);
    @(posedge clk_sys_i);
    addr_i <= a;
    wdata_i <= 64'(v);
    wr_i <= w;
    rd_i <= !w;
    @(posedge clk_sys_i);
    wr_i <= 0;
    rd_i <= 0;
    #1;
  endtask
  function automatic logic [63:0] st();
    logic [63:0] s;
    s = 64'(fl);
    s[7] = |s[3:0];
    s[8] = cfg[0];
    s[9] = cfg[1];
    s[10] = (s[6] & cfg[2]) | (s[5] & cfg[3]);
    s[11] = s[7];
    return s;
  endfunction
  task automatic test_done();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    n_fail++;
    test_done();
  end
  initial
  begin
    void'($urandom(99));
    repeat (10) @(posedge clk_sys_i);
    rst_i <= 0;
    bus(0, STATUS_OFF, 0);
    chk("status", rdata_o, st());
    bus(0, 8'h20, 0);
    chk("unmapped", rdata_o, 64'h0);
    for (k = 0; k < 16; k++)
    begin
      i = k < 7 ? k : $urandom_range(6);
      m = $urandom_range(127);
      d = $urandom;
      cfg = $urandom_range(15);
      bus(1, CONFIG_OFF, cfg);
      bus(1, IRQ_MASK_OFF, m);
      bus(1, STATUS_OFF, d);
      fl &= ~d;
      @(posedge clk_sys_i);
      req <= 7'(1 << i);
      @(posedge clk_sys_i);
      req <= 7'h00;
      // chain errors count only while chaining is enabled
      h = i inside {0, 3} || (i == 1 && cfg[1]);
      if (i inside {0, 3, 4, 5} || (i inside {1, 2} && cfg[1]))
        fl |= 1 << (i < 4 ? i : i + 1);
      if (h || i == 6)
        cfg &= 32'hE;
      @(posedge clk_sys_i);
      #1;
      chk("halt", 64'(halt_o), 64'(h));
      bus(0, STATUS_OFF, 0);
      chk("status", rdata_o, st());
      chk("active", 64'(act_o), 64'(cfg[0]));
      chk("chain", 64'(ch_o), 64'(cfg[1]));
      chk("irq", 64'(irq_o), 64'(|(fl & m)));
    end
    test_done();
  end
endmodule
